// File: core/cai_chan.sv
`timescale 1ns/10ps
module cai_chan #(
	parameter int TICK_CYCLES = cai_pkg::STEP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	cai_chan_if.chan c
);
	import cai_pkg::*;

	localparam int SUB_W = $clog2(TICK_CYCLES);
	localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(TICK_CYCLES - 1);

	typedef struct packed {
		logic [SUB_W-1:0] sub;
		logic [DLY_W-1:0] steps;
		logic             qual;
		logic             alarm;
		logic             recog;
		logic             clear_evt;
	} cai_chan_st_s;

	cai_chan_st_s st_reg;
	cai_chan_st_s st_next;

	if (TICK_CYCLES < 2) begin : g_chk
		$error("cai_chan: TICK_CYCLES must be at least 2");
	end

	always_comb begin
		st_next           = st_reg;
		st_next.recog     = 1'b0;
		st_next.clear_evt = 1'b0;
		if (!c.contact) begin
			st_next.sub   = '0;
			st_next.steps = '0;
			st_next.qual  = 1'b0;
		end else if (!st_reg.qual) begin
			if (st_reg.steps >= c.cfg.delay) begin
				st_next.qual  = 1'b1;
				st_next.recog = 1'b1;
				st_next.alarm = 1'b1;
			end else if (st_reg.sub == SUB_LAST) begin
				st_next.sub   = '0;
				st_next.steps = st_reg.steps + 1'b1;
			end else begin
				st_next.sub = st_reg.sub + 1'b1;
			end
		end
		if (st_reg.alarm && !c.contact
			&& (!c.cfg.latch || c.clr_press)) begin
			st_next.alarm     = 1'b0;
			st_next.clear_evt = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign c.alarm     = st_reg.alarm;
	assign c.recog     = st_reg.recog;
	assign c.clear_evt = st_reg.clear_evt;
endmodule

// File: core/cai_chan_if.sv
`timescale 1ns/10ps
interface cai_chan_if;
	import cai_pkg::*;
	cai_cfg_s cfg;
	logic     contact;
	logic     clr_press;
	logic     alarm;
	logic     recog;
	logic     clear_evt;
	modport ctl (output cfg, contact, clr_press,
		input alarm, recog, clear_evt);
	modport chan (input cfg, contact, clr_press,
		output alarm, recog, clear_evt);
endinterface

// File: core/cai_pkg.sv
package cai_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int NCH   = 8;
	localparam int DLY_W = 10;
	localparam int CFG_W = 17;

	// ****************************************
	// timing
	// ****************************************
	// delay step 0.1 s, longest delay 99.9 s
	localparam int STEP_MS = 100;
	localparam int CLK_KHZ = 100000;
	localparam int STEP_CYCLES = STEP_MS * CLK_KHZ;
	localparam logic [DLY_W-1:0] DLY_MAX = 10'h3e7;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFF_STATUS   = 8'h00;
	localparam logic [7:0] OFF_INT_STAT = 8'h04;
	localparam logic [7:0] OFF_INT_EN   = 8'h08;
	localparam logic [7:0] OFF_INT_CLR  = 8'h0c;
	localparam logic [7:0] OFF_CTRL     = 8'h10;
	localparam logic [2:0] BLK_CFG      = 3'h1;
	localparam logic [2:0] BLK_NAME     = 3'h2;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CFG_LATCH   = 0;
	localparam int CFG_DIAL    = 1;
	localparam int CFG_FREEZE  = 2;
	localparam int CFG_EVENT   = 3;
	localparam int CFG_INVERT  = 4;
	localparam int CFG_RLY_EN  = 5;
	localparam int CFG_RLY_NC  = 6;
	localparam int CFG_CUSTOM  = 7;
	localparam int CFG_DLY_LSB = 16;
	localparam int CTRL_EN     = 0;
	localparam int CTRL_SWRST  = 1;
	localparam int STAT_BOARD  = 16;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [15:0] INT_EN_RST = 16'h0000;
	localparam logic [23:0] DEF_PREFIX = 24'h494e23;
	localparam logic [7:0] DEF_DIGIT0 = 8'h31;

	typedef struct packed {
		logic             latch;
		logic             dial;
		logic             event_log;
		logic             invert;
		logic             relay_en;
		logic             relay_nc;
		logic             custom;
		logic [DLY_W-1:0] delay;
	} cai_cfg_s;

endpackage

// File: core/cai_sync.sv
`timescale 1ns/10ps
module cai_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] q;
	} cai_sync_s;

	cai_sync_s sync_reg;
	cai_sync_s sync_next;

	if (WIDTH < 1) begin : g_chk
		$error("cai_sync: WIDTH must be at least 1");
	end

	// first stage feeds only the second
	always_comb begin
		sync_next      = sync_reg;
		sync_next.meta = d;
		sync_next.q    = sync_reg.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign q = sync_reg.q;
endmodule

// File: core/cai_top.sv
// Contract
// - eight contact inputs, each with its own settings
// - latched alarm stays until contact opens and reset pressed after
// - unlatched alarm drops as soon as contact opens
// - recognition delay 0 to 99.9 s in 0.1 s steps
// - latching input latches only after the delay
// - event enabled: log entry on each recognition
// - event disabled: no log entry at all
// - dial enabled: dial-out request on recognition
// - freeze reads no, ignores writes, no effect
// - recognised alarm may drive relay board, open or closed type
// - reports carry custom name once one is set
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
module cai_top #(
	parameter int TICK_CYCLES = cai_pkg::STEP_CYCLES
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic [7:0]              paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic [cai_pkg::NCH-1:0] contact_n,
	input  wire logic                    alarm_reset_n,
	input  wire logic                    relay_board_present,
	input  wire logic [2:0]              rpt_idx,
	output logic      [31:0]             rpt_name,
	output logic      [cai_pkg::NCH-1:0] alarm,
	output logic      [cai_pkg::NCH-1:0] dial_req,
	output logic      [cai_pkg::NCH-1:0] evlog_req,
	output logic      [cai_pkg::NCH-1:0] relay_drive,
	output logic      [cai_pkg::NCH-1:0] relay_nc_sel,
	output logic                         irq
);
	import cai_pkg::*;

	// ****************************************
	// checks
	// ****************************************
	if (TICK_CYCLES < 2) begin : g_chk
		$error("cai_top: TICK_CYCLES must be at least 2");
	end

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		cai_cfg_s [NCH-1:0]    cfg;
		logic [NCH-1:0][31:0]  name;
		logic [15:0]           int_stat;
		logic [15:0]           int_en;
		logic                  sys_en;
		logic                  sw_reset;
		logic                  btn_prev;
		logic [31:0]           prdata;
		logic                  pslverr;
		logic [31:0]           rpt_name;
		logic [NCH-1:0]        dial_req;
		logic [NCH-1:0]        evlog_req;
		logic [NCH-1:0]        relay_drive;
		logic [NCH-1:0]        relay_nc_sel;
	} cai_top_s;

	cai_top_s top_reg;
	cai_top_s top_next;

	logic [NCH+1:0] pins_s;
	logic [NCH-1:0] closed;
	logic           board_s;
	logic           btn_s;
	logic           press;
	logic [NCH-1:0] alarm_v;
	logic [NCH-1:0] recog_v;
	logic [NCH-1:0] clear_v;

	// ****************************************
	// pin synchronisers
	// ****************************************
	// contacts are asynchronous to pclk
	// inverted ahead of the flops so reset reads as idle, no false press
	cai_sync #(
		.WIDTH (NCH + 2)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({relay_board_present, ~alarm_reset_n, ~contact_n}),
		.q       (pins_s)
	);

	assign closed  = pins_s[NCH-1:0];
	assign btn_s   = pins_s[NCH];
	assign board_s = pins_s[NCH+1];

	// only a fresh press counts, holding it does nothing more
	assign press = btn_s & ~top_reg.btn_prev;

	// ****************************************
	// channels
	// ****************************************
	cai_chan_if ch_if[NCH] ();

	for (genvar g = 0; g < NCH; g++) begin : g_ch
		assign ch_if[g].cfg = top_reg.cfg[g];
		assign ch_if[g].contact = top_reg.sys_en
			& (closed[g] ^ top_reg.cfg[g].invert);
		assign ch_if[g].clr_press = press | top_reg.sw_reset;
		assign alarm_v[g] = ch_if[g].alarm;
		assign recog_v[g] = ch_if[g].recog;
		assign clear_v[g] = ch_if[g].clear_evt;

		cai_chan #(
			.TICK_CYCLES (TICK_CYCLES)
		) u_chan (
			.pclk    (pclk),
			.presetn (presetn),
			.c       (ch_if[g].chan)
		);
	end

	// ****************************************
	// register decode
	// ****************************************
	function automatic logic addr_ok(input logic [7:0] a);
		logic ok;
		ok = 1'b0;
		if (a[1:0] == 2'h0) begin
			if (a[7:5] == BLK_CFG || a[7:5] == BLK_NAME) begin
				ok = 1'b1;
			end
			if (a == OFF_STATUS || a == OFF_INT_STAT
				|| a == OFF_INT_EN || a == OFF_INT_CLR
				|| a == OFF_CTRL) begin
				ok = 1'b1;
			end
		end
		return ok;
	endfunction

	function automatic logic [31:0] cfg_word(input cai_cfg_s f);
		logic [31:0] w;
		w = '0;
		w[CFG_LATCH]  = f.latch;
		w[CFG_DIAL]   = f.dial;
		w[CFG_FREEZE] = 1'b0;
		w[CFG_EVENT]  = f.event_log;
		w[CFG_INVERT] = f.invert;
		w[CFG_RLY_EN] = f.relay_en;
		w[CFG_RLY_NC] = f.relay_nc;
		w[CFG_CUSTOM] = f.custom;
		w[CFG_DLY_LSB +: DLY_W] = f.delay;
		return w;
	endfunction

	function automatic cai_cfg_s cfg_from(input logic [31:0] w);
		cai_cfg_s f;
		logic [DLY_W-1:0] d;
		d = w[CFG_DLY_LSB +: DLY_W];
		f.latch     = w[CFG_LATCH];
		f.dial      = w[CFG_DIAL];
		f.event_log = w[CFG_EVENT];
		f.invert    = w[CFG_INVERT];
		f.relay_en  = w[CFG_RLY_EN];
		f.relay_nc  = w[CFG_RLY_NC];
		f.custom    = w[CFG_CUSTOM];
		f.delay = (d > DLY_MAX) ? DLY_MAX : d;
		return f;
	endfunction

	function automatic logic [31:0] rd_mux(
		input cai_top_s s,
		input logic [7:0] a,
		input logic [NCH-1:0] alm,
		input logic [NCH-1:0] cls,
		input logic brd);
		logic [31:0] v;
		v = '0;
		if (a[7:5] == BLK_CFG) begin
			v = cfg_word(s.cfg[a[4:2]]);
		end else if (a[7:5] == BLK_NAME) begin
			v = s.name[a[4:2]];
		end else begin
			case (a)
				OFF_STATUS: begin
					v[NCH-1:0]      = alm;
					v[2*NCH-1:NCH]  = cls;
					v[STAT_BOARD]   = brd;
				end
				OFF_INT_STAT: begin
					v[15:0] = s.int_stat;
				end
				OFF_INT_EN: begin
					v[15:0] = s.int_en;
				end
				OFF_CTRL: begin
					v[CTRL_EN] = s.sys_en;
				end
				default: begin
					v = '0;
				end
			endcase
		end
		return v;
	endfunction

	// ****************************************
	// next state
	// ****************************************
	logic        setup_ph;
	logic        wr_acc;
	logic [15:0] int_set;
	logic [15:0] int_clr;
	logic [7:0]  rpt_digit;

	assign setup_ph = psel & ~penable;
	assign wr_acc   = psel & penable & pwrite & addr_ok(paddr);
	assign int_set  = {clear_v, recog_v};
	assign rpt_digit = DEF_DIGIT0 + {5'h00, rpt_idx};

	always_comb begin
		top_next          = top_reg;
		top_next.sw_reset = 1'b0;
		top_next.btn_prev = btn_s;
		int_clr           = '0;

		// read data captured in setup, shown in access
		if (setup_ph) begin
			top_next.pslverr = ~addr_ok(paddr);
			if (pwrite) begin
				top_next.prdata = '0;
			end else begin
				top_next.prdata = rd_mux(top_reg, paddr,
					alarm_v, closed, board_s);
			end
		end

		if (wr_acc) begin
			if (paddr[7:5] == BLK_CFG) begin
				top_next.cfg[paddr[4:2]] = cfg_from(pwdata);
			end else if (paddr[7:5] == BLK_NAME) begin
				top_next.name[paddr[4:2]] = pwdata;
			end else begin
				case (paddr)
					OFF_INT_EN: begin
						top_next.int_en = pwdata[15:0];
					end
					OFF_INT_CLR: begin
						int_clr = pwdata[15:0];
					end
					OFF_CTRL: begin
						top_next.sys_en   = pwdata[CTRL_EN];
						top_next.sw_reset = pwdata[CTRL_SWRST];
					end
					default: begin
						top_next.sys_en = top_reg.sys_en;
					end
				endcase
			end
		end

		// a new event beats a clear in the same cycle
		top_next.int_stat = (top_reg.int_stat & ~int_clr) | int_set;

		for (int i = 0; i < NCH; i++) begin
			top_next.dial_req[i] = recog_v[i] & top_reg.cfg[i].dial;
			top_next.evlog_req[i] = recog_v[i]
				& top_reg.cfg[i].event_log;
			top_next.relay_drive[i] = board_s & alarm_v[i]
				& top_reg.cfg[i].relay_en;
			top_next.relay_nc_sel[i] = board_s
				& top_reg.cfg[i].relay_nc;
		end

		if (top_reg.cfg[rpt_idx].custom) begin
			top_next.rpt_name = top_reg.name[rpt_idx];
		end else begin
			top_next.rpt_name = {DEF_PREFIX, rpt_digit};
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			top_reg        <= '0;
			top_reg.sys_en <= CTRL_EN_RST;
			top_reg.int_en <= INT_EN_RST;
		end else begin
			top_reg <= top_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// zero-wait slave: answer is ready in the first access cycle
	assign pready       = 1'b1;
	assign prdata       = top_reg.prdata;
	assign pslverr      = top_reg.pslverr;
	assign rpt_name     = top_reg.rpt_name;
	assign alarm        = alarm_v;
	assign dial_req     = top_reg.dial_req;
	assign evlog_req    = top_reg.evlog_req;
	assign relay_drive  = top_reg.relay_drive;
	assign relay_nc_sel = top_reg.relay_nc_sel;
	assign irq          = |(top_reg.int_stat & top_reg.int_en);

endmodule

// File: verification/cai_asserts.sv
`timescale 1ns/10ps
module cai_asserts #(
	parameter int TICK_CYCLES = cai_pkg::STEP_CYCLES
) (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic [7:0]              paddr,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic                    relay_board_present,
	input wire logic [cai_pkg::NCH-1:0] alarm,
	input wire logic [cai_pkg::NCH-1:0] dial_req,
	input wire logic [cai_pkg::NCH-1:0] evlog_req,
	input wire logic [cai_pkg::NCH-1:0] relay_drive,
	input wire logic [cai_pkg::NCH-1:0] relay_nc_sel
);
	import cai_pkg::*;
	// ****************************************
	// port relations
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// pulses only one edge after a fresh rise
	chk_dial_on_rise: assert property (
		(dial_req & ~($past(alarm) & ~$past(alarm, 2))) == '0)
		else $error("dial request without new alarm");
	chk_log_on_rise: assert property (
		(evlog_req & ~($past(alarm) & ~$past(alarm, 2))) == '0)
		else $error("log request without new alarm");
	chk_freeze_zero: assert property (
		psel && penable && !pwrite && paddr[7:5] == BLK_CFG
		|-> !prdata[CFG_FREEZE])
		else $error("freeze bit reads one");
	chk_relay_follows: assert property (
		(relay_drive & ~(alarm | $past(alarm))) == '0)
		else $error("relay driven without alarm");
	// sync plus register: three low samples
	chk_board_gate: assert property (
		!relay_board_present [*3] |=> (relay_drive | relay_nc_sel) == '0)
		else $error("relay outputs without board");
	chk_access_ready: assert property (psel && penable |-> pready)
		else $error("pready low in access");
	chk_unaligned_err: assert property (
		psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("no error on unaligned access");
	chk_clear_reads: assert property (
		psel && penable && !pwrite && paddr == OFF_INT_CLR |-> prdata == '0)
		else $error("clear register reads nonzero");
endmodule

// File: verification/cai_contacts.sv
`timescale 1ns/10ps
module cai_contacts (
	input wire logic                    pclk,
	input wire logic [cai_pkg::NCH-1:0] closed,
	input wire logic [cai_pkg::NCH-1:0] evlog_req,
	input wire logic [cai_pkg::NCH-1:0] dial_req,
	output logic     [cai_pkg::NCH-1:0] contact_n
);
	import cai_pkg::*;
	int logs[NCH] = '{default: 0};
	int dials[NCH] = '{default: 0};
	assign contact_n = ~closed;
	// log and modem side just count requests
	always @(posedge pclk) begin
		for (int i = 0; i < NCH; i++) begin
			logs[i] += evlog_req[i];
			dials[i] += dial_req[i];
		end
	end
endmodule

// File: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import cai_pkg::*;
	localparam int T = 4;
	logic           pclk = 0;
	logic           presetn = 0;
	logic           psel = 0;
	logic           penable = 0;
	logic           pwrite = 0;
	logic [7:0]     paddr = '0;
	logic [31:0]    pwdata = '0;
	logic [31:0]    prdata, rpt_name, rd;
	logic           pready, pslverr, irq, err;
	logic [NCH-1:0] closed = '0;
	logic [NCH-1:0] contact_n, alarm, dial_req, evlog_req;
	logic [NCH-1:0] relay_drive, relay_nc_sel;
	logic           press_n = 1;
	logic           board = 0;
	logic [2:0]     rpt_idx = '0;
	int             failures = 0;
	int             checks = 0;
	int             seed = 32'h458d;
	int             k;
	always #5 pclk = ~pclk;
	cai_top #(.TICK_CYCLES(T)) dut_u (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .contact_n(contact_n), .alarm_reset_n(press_n),
		.relay_board_present(board), .rpt_idx(rpt_idx),
		.rpt_name(rpt_name), .alarm(alarm), .dial_req(dial_req),
		.evlog_req(evlog_req), .relay_drive(relay_drive),
		.relay_nc_sel(relay_nc_sel), .irq(irq));
	cai_contacts model_u (.pclk(pclk), .closed(closed),
		.evlog_req(evlog_req), .dial_req(dial_req), .contact_n(contact_n));
	// ****************************************
	// tasks
	// ****************************************
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic give_verdict;
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic press(input int n);
		press_n <= 1'b0;
		repeat (n) @(posedge pclk);
		press_n <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask
	// alarm is seen one edge after it is set
	task automatic wait_alarm(input int n, input int e);
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (alarm[n] !== 1'b1 && k < 5000);
		cmp(k, e);
	endtask
	task automatic chan(input int n);
		logic [31:0] c;
		c = ($random(seed) & 32'h0003006b) | 32'h80;
		apb(1, 8'(32'h20 + 4 * n), c);
		apb(1, 8'(32'h40 + 4 * n), 32'h41424330 + n);
		rpt_idx <= 3'(n);
		closed[n] <= 1'b1;
		wait_alarm(n, int'(c[17:16]) * T + 4);
		repeat (3) @(posedge pclk);
		cmp(model_u.logs[n], 32'(c[3]));
		cmp(model_u.dials[n], 32'(c[1]));
		cmp({relay_nc_sel[n], relay_drive[n]}, c[6:5]);
		cmp(rpt_name, 32'h41424330 + n);
		cmp(irq, 1);
		apb(0, OFF_INT_STAT, 0);
		cmp(rd[n], 1);
		press(3);
		closed[n] <= 1'b0;
		repeat (8) @(posedge pclk);
		cmp(alarm[n], c[0]);
		press(6);
		cmp(alarm[n], 0);
		apb(1, OFF_INT_CLR, 32'hffff);
		cmp(irq, 0);
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, OFF_CTRL, 0);
		cmp(rd, 32'h1);
		apb(0, 8'h81, 0);
		cmp(err, 1);
		apb(0, OFF_INT_CLR, 0);
		cmp(rd, 0);
		apb(1, 8'h20, 32'h03ff00ff);
		apb(0, 8'h20, 0);
		cmp(rd, 32'h03e700fb);
		board <= 1'b1;
		apb(1, OFF_INT_EN, 32'hff);
		for (int n = 0; n < NCH; n++) chan(n);
		apb(1, 8'h20, 32'h00020000);
		closed[0] <= 1'b1;
		repeat (T) @(posedge pclk);
		closed[0] <= 1'b0;
		repeat (3) @(posedge pclk);
		closed[0] <= 1'b1;
		wait_alarm(0, 2 * T + 4);
		apb(1, OFF_INT_EN, 0);
		cmp(irq, 0);
		apb(0, OFF_INT_STAT, 0);
		cmp(rd[0], 1);
		rpt_idx <= 3'h0;
		repeat (2) @(posedge pclk);
		cmp(rpt_name, {DEF_PREFIX, DEF_DIGIT0});
		give_verdict;
	end
	// whole run is under five hundred cycles
	initial begin
		#300000;
		failures++;
		give_verdict;
	end
endmodule
bind cai_top cai_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.*);
